// ===== ttd_pkg.sv
// ttd_pkg: constants, types and decode helpers for the ttl trigger detector
// assumes a 32-bit classic wishbone slave addressed by byte, one word per register
package ttd_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int MODE_W = 5;
  localparam int MASK_W = 4;
  localparam int IRQ_W  = 2;
  localparam int IDX_W  = ADDR_W - 2;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OR_TRIGGER_MASK  = 16'h9DDA;
  localparam logic [IDX_W-1:0] IDX_LINE0_TRIG_MODE  = 16'h9E3F;
  localparam logic [IDX_W-1:0] IDX_LINE1_TRIG_MODE  = 16'h9E40;
  localparam logic [IDX_W-1:0] IDX_ACQ_CTRL         = 16'h9F00;
  localparam logic [IDX_W-1:0] IDX_ACQ_STATUS       = 16'h9F01;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS       = 16'h9F02;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR        = 16'h9F03;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE       = 16'h9F04;

  // trigger mode encodings
  localparam logic [MODE_W-1:0] MODE_DISABLED     = 5'h00;
  localparam logic [MODE_W-1:0] MODE_RISING_EDGE  = 5'h01;
  localparam logic [MODE_W-1:0] MODE_FALLING_EDGE = 5'h02;
  localparam logic [MODE_W-1:0] MODE_ANY_EDGE     = 5'h04;
  localparam logic [MODE_W-1:0] MODE_HIGH_LEVEL   = 5'h08;
  localparam logic [MODE_W-1:0] MODE_LOW_LEVEL    = 5'h10;
  localparam logic [MODE_W-1:0] MODE_RESET        = MODE_DISABLED;

  // or mask field positions (values 4h and 8h)
  localparam int OR_MASK_LINE0_BIT = 2;
  localparam int OR_MASK_LINE1_BIT = 3;
  localparam logic [MASK_W-1:0] OR_MASK_WR_MASK = 4'hC;
  localparam logic [MASK_W-1:0] OR_MASK_RESET   = 4'h0;

  // control and status fields
  localparam int CTRL_ARM_BIT  = 0;
  localparam int CTRL_DONE_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LEVEL_LSB = 2;
  localparam int STAT_GATE_LSB  = 4;
  localparam int IRQ_TRIG_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RECORD} ttd_state_e;

  typedef struct packed {
    logic rise;
    logic fall;
    logic any;
    logic high;
    logic low;
  } ttd_mode_s;

  // unknown codes decode to nothing, so they behave as disabled
  function automatic ttd_mode_s ttd_decode(input logic [MODE_W-1:0] m);
    ttd_mode_s d;
    d.rise = (m == MODE_RISING_EDGE);
    d.fall = (m == MODE_FALLING_EDGE);
    d.any  = (m == MODE_ANY_EDGE);
    d.high = (m == MODE_HIGH_LEVEL);
    d.low  = (m == MODE_LOW_LEVEL);
    return d;
  endfunction : ttd_decode

endpackage : ttd_pkg

// ===== ttd_trigger_detector.sv
// ttd_trigger_detector: edge and level trigger detection on two ttl lines
// assumes lines are asynchronous pins, rec_done_i and the bus run on core_clk_i
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
module ttd_trigger_detector
  import ttd_pkg::*;
#(
  parameter int LINES = 2
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [LINES-1:0]  multipurpose_line_i,
  input  wire logic              rec_done_i,
  output logic                   trig_o,
  output logic      [LINES-1:0]  gate_o,
  output logic                   armed_o,
  output logic                   irq_o
);

  localparam int OR_MASK_BIT [2] = '{OR_MASK_LINE0_BIT, OR_MASK_LINE1_BIT};

  logic [LINES-1:0]  sync1_reg;
  logic [LINES-1:0]  cur_reg;
  logic [LINES-1:0]  prev_reg;
  logic [MODE_W-1:0] mode_reg [LINES];
  logic [MASK_W-1:0] mask_reg;
  ttd_state_e        state_reg;
  ttd_state_e        state_next;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_stat_next;
  logic [IRQ_W-1:0]  irq_en_reg;

  logic [LINES-1:0]  hit_w;
  logic [LINES-1:0]  gate_w;
  logic              fire_w;
  logic              req_w;
  logic              wr_w;
  logic [IDX_W-1:0]  idx_w;
  logic              wr_lo_w;
  logic              arm_w;
  logic              done_w;
  logic [IRQ_W-1:0]  irq_ev_w;
  logic [IRQ_W-1:0]  irq_clr_w;
  logic [DATA_W-1:0] rdata_w;
  logic [DATA_W-1:0] status_w;

  // bus decode
  assign req_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_w    = req_w & wb_we_i;
  assign idx_w   = wb_adr_i[ADDR_W-1:2];
  assign wr_lo_w = wr_w & wb_sel_i[0];

  // per-line detection
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      ttd_mode_s m_w;
      logic      rise_w;
      logic      fall_w;
      assign m_w    = ttd_decode(mode_reg[gi]);
      assign rise_w = cur_reg[gi] & ~prev_reg[gi];
      assign fall_w = ~cur_reg[gi] & prev_reg[gi];
      assign gate_w[gi] = (m_w.high & cur_reg[gi]) | (m_w.low & ~cur_reg[gi]);
      // a level hit covers both the entering moment and the already-present case
      assign hit_w[gi] = mask_reg[OR_MASK_BIT[gi]] &
                         ((m_w.rise & rise_w) |
                          (m_w.fall & fall_w) |
                          (m_w.any & (rise_w | fall_w)) |
                          gate_w[gi]);

      always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
          mode_reg[gi] <= MODE_RESET;
        end else if (ce_i && wr_lo_w && idx_w == IDX_LINE0_TRIG_MODE + IDX_W'(gi)) begin
          mode_reg[gi] <= wb_dat_i[MODE_W-1:0];
        end
      end
    end : g_line
  endgenerate

  // only an armed block fires, so a second edge in recording is dropped
  assign fire_w = (state_reg == ST_ARMED) & (|hit_w);
  assign arm_w  = wr_lo_w & (idx_w == IDX_ACQ_CTRL) & wb_dat_i[CTRL_ARM_BIT];
  assign done_w = rec_done_i | (wr_lo_w & (idx_w == IDX_ACQ_CTRL) & wb_dat_i[CTRL_DONE_BIT]);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   if (arm_w) state_next = ST_ARMED;
      ST_ARMED:  if (fire_w) state_next = ST_RECORD;
      ST_RECORD: if (done_w) state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  // interrupt bookkeeping; a new event beats a simultaneous clear
  assign irq_ev_w[IRQ_TRIG_BIT] = fire_w;
  assign irq_ev_w[IRQ_DONE_BIT] = (state_reg == ST_RECORD) & done_w;
  assign irq_clr_w     = (wr_lo_w && idx_w == IDX_IRQ_CLEAR) ? wb_dat_i[IRQ_W-1:0] : IRQ_RESET;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr_w) | irq_ev_w;

  assign status_w = DATA_W'({gate_w, cur_reg, state_reg});

  assign rdata_w = (idx_w == IDX_LINE0_TRIG_MODE) ? DATA_W'(mode_reg[0]) :
                   (idx_w == IDX_LINE1_TRIG_MODE) ? DATA_W'(mode_reg[1]) :
                   (idx_w == IDX_OR_TRIGGER_MASK) ? DATA_W'(mask_reg) :
                   (idx_w == IDX_ACQ_STATUS)      ? status_w :
                   (idx_w == IDX_IRQ_STATUS)      ? DATA_W'(irq_stat_reg) :
                   (idx_w == IDX_IRQ_ENABLE)      ? DATA_W'(irq_en_reg) :
                   '0;

  // two flops for the asynchronous pins, then a previous-sample register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sync1_reg <= '0;
      cur_reg   <= '0;
      prev_reg  <= '0;
    end else if (ce_i) begin
      sync1_reg <= multipurpose_line_i;
      cur_reg   <= sync1_reg;
      prev_reg  <= cur_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      mask_reg <= OR_MASK_RESET;
    end else if (ce_i && wr_lo_w && idx_w == IDX_OR_TRIGGER_MASK) begin
      mask_reg <= wb_dat_i[MASK_W-1:0] & OR_MASK_WR_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      irq_en_reg <= IRQ_RESET;
    end else if (ce_i && wr_lo_w && idx_w == IDX_IRQ_ENABLE) begin
      irq_en_reg <= wb_dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_reg    <= ST_IDLE;
      irq_stat_reg <= IRQ_RESET;
      trig_o       <= 1'b0;
      gate_o       <= '0;
      armed_o      <= 1'b0;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      state_reg    <= state_next;
      irq_stat_reg <= irq_stat_next;
      trig_o       <= fire_w;
      gate_o       <= gate_w;
      armed_o      <= (state_next == ST_ARMED);
      irq_o        <= |(irq_stat_next & irq_en_reg);
    end
  end

  // one-wait-state slave; ack drops the cycle after it is given
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= req_w;
      if (req_w && !wb_we_i) begin
        wb_dat_o <= rdata_w;
      end
    end
  end

  // checks
  property p_mode_indep;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && wr_lo_w && idx_w == IDX_LINE1_TRIG_MODE) |=> $stable(mode_reg[0]);
  endproperty
  a_mode_indep: assert property (p_mode_indep) else $error("line1 write changed line0 mode");

  property p_rise_fires;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[0] == MODE_RISING_EDGE && mask_reg[OR_MASK_LINE0_BIT]
       && cur_reg[0] && !prev_reg[0]) |=> trig_o ##1 !trig_o || !$past(ce_i, 1) || !ce_i;
  endproperty
  a_rise_fires: assert property (p_rise_fires) else $error("rising edge missed");

  property p_no_refire;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg != ST_ARMED) |=> !trig_o;
  endproperty
  a_no_refire: assert property (p_no_refire) else $error("trigger while not armed");

  property p_fall_fires;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[1] == MODE_FALLING_EDGE && mask_reg[OR_MASK_LINE1_BIT]
       && !cur_reg[1] && prev_reg[1]) |=> trig_o && state_reg == ST_RECORD;
  endproperty
  a_fall_fires: assert property (p_fall_fires) else $error("falling edge missed");

  property p_any_fires;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[0] == MODE_ANY_EDGE && mask_reg[OR_MASK_LINE0_BIT]
       && cur_reg[0] != prev_reg[0]) |=> trig_o;
  endproperty
  a_any_fires: assert property (p_any_fires) else $error("edge in any-edge mode missed");

  property p_gate_high;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && mode_reg[0] == MODE_HIGH_LEVEL) |=> gate_o[0] == $past(cur_reg[0]);
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("gate does not follow high level");

  property p_high_now;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[0] == MODE_HIGH_LEVEL && mask_reg[OR_MASK_LINE0_BIT]
       && cur_reg[0]) |=> trig_o;
  endproperty
  a_high_now: assert property (p_high_now) else $error("high level did not fire at once");

  property p_low_now;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[1] == MODE_LOW_LEVEL && mask_reg[OR_MASK_LINE1_BIT]
       && !cur_reg[1]) |=> trig_o;
  endproperty
  a_low_now: assert property (p_low_now) else $error("low level did not fire at once");

  property p_disabled;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mode_reg[0] == MODE_DISABLED) |-> !hit_w[0] && !gate_w[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled line produced a hit");

  property p_masked;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !mask_reg[OR_MASK_LINE1_BIT] |-> !hit_w[1];
  endproperty
  a_masked: assert property (p_masked) else $error("masked line produced a hit");

  property p_edge_src;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mode_reg[0] == MODE_RISING_EDGE && hit_w[0]) |-> cur_reg[0] && !prev_reg[0];
  endproperty
  a_edge_src: assert property (p_edge_src) else $error("edge hit without sample change");

  property p_mode_write;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && wr_lo_w && idx_w == IDX_LINE0_TRIG_MODE) |=> mode_reg[0] == $past(wb_dat_i[MODE_W-1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("line0 mode write lost");

  property p_mode0_indep;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && wr_lo_w && idx_w == IDX_LINE0_TRIG_MODE) |=> $stable(mode_reg[1]);
  endproperty
  a_mode0_indep: assert property (p_mode0_indep) else $error("line0 write changed line1 mode");

  property p_ack_answer;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("bus request not acknowledged");

  property p_ack_pulse;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && wb_ack_o) |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_ack_quiet;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && !wb_cyc_i) |=> !wb_ack_o;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet) else $error("ack without a cycle");

  property p_idle_waits;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_IDLE && !arm_w) |=> state_reg == ST_IDLE && !trig_o;
  endproperty
  a_idle_waits: assert property (p_idle_waits) else $error("left idle or fired without arming");

  property p_armed_out;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i |=> armed_o == (state_reg == ST_ARMED);
  endproperty
  a_armed_out: assert property (p_armed_out) else $error("armed output disagrees with state");

  property p_record_holds;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_RECORD && !done_w) |=> state_reg == ST_RECORD;
  endproperty
  a_record_holds: assert property (p_record_holds) else $error("recording left before done");

  property p_done_idles;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_RECORD && done_w) |=> state_reg == ST_IDLE;
  endproperty
  a_done_idles: assert property (p_done_idles) else $error("done did not return to idle");

  property p_sample_chain;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i |=> cur_reg == $past(sync1_reg);
  endproperty
  a_sample_chain: assert property (p_sample_chain) else $error("line sample skipped");

  property p_gate_low;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && mode_reg[0] == MODE_LOW_LEVEL) |=> gate_o[0] == !$past(cur_reg[0]);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate does not follow low level");

  property p_gate_edge;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && mode_reg[0] != MODE_HIGH_LEVEL && mode_reg[0] != MODE_LOW_LEVEL) |=> !gate_o[0];
  endproperty
  a_gate_edge: assert property (p_gate_edge) else $error("gate outside level modes");

  property p_high_enter;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[0] == MODE_HIGH_LEVEL && mask_reg[OR_MASK_LINE0_BIT]
       && cur_reg[0] && !prev_reg[0]) |=> trig_o;
  endproperty
  a_high_enter: assert property (p_high_enter) else $error("entering high level missed");

  property p_low_enter;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (ce_i && state_reg == ST_ARMED && mode_reg[0] == MODE_LOW_LEVEL && mask_reg[OR_MASK_LINE0_BIT]
       && !cur_reg[0] && prev_reg[0]) |=> trig_o;
  endproperty
  a_low_enter: assert property (p_low_enter) else $error("entering low level missed");

  property p_disabled1;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mode_reg[1] == MODE_DISABLED) |-> !hit_w[1] && !gate_w[1];
  endproperty
  a_disabled1: assert property (p_disabled1) else $error("disabled line1 produced a hit");

  property p_masked0;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !mask_reg[OR_MASK_LINE0_BIT] |-> !hit_w[0];
  endproperty
  a_masked0: assert property (p_masked0) else $error("masked line0 produced a hit");

  property p_fall_src;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mode_reg[0] == MODE_FALLING_EDGE && hit_w[0]) |-> !cur_reg[0] && prev_reg[0];
  endproperty
  a_fall_src: assert property (p_fall_src) else $error("falling hit without sample change");

  property p_prev_chain;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ce_i |=> prev_reg == $past(cur_reg);
  endproperty
  a_prev_chain: assert property (p_prev_chain) else $error("previous sample not kept");

endmodule : ttd_trigger_detector

// ===== ttd_ttl_source.sv
// ttd_ttl_source: behavioural external ttl source for the two trigger lines
// assumes the bench calls set_line from its clocked sequence
`timescale 1ns/1ns
module ttd_ttl_source (
  input  wire logic       clk_i,
  output logic      [1:0] line_o
);
  initial line_o = 2'h0;
  // push-pull ttl driver: a line always shows a defined level, no released state
  task automatic set_line(input int idx, input logic val);
    @(posedge clk_i);
    line_o[idx] <= val;
  endtask : set_line
endmodule : ttd_ttl_source

// ===== tb.sv
// tb: table-driven bench for the ttl trigger detector
// assumes the design answers the wishbone bus with a registered ack
`timescale 1ns/1ns
module tb;
  import ttd_pkg::*;
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic              ln;
    logic [3:0]        msk;
    logic              l0;
    logic              l1;
    logic [1:0]        e0;
    logic [1:0]        e1;
  } ttd_row_s;
  logic              core_clk_i = 1'h0;
  logic              rst_b_i    = 1'h0;
  logic              cyc = 1'h0, stb = 1'h0, we = 1'h0, rec_done = 1'h0, ce = 1'h1;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] dat = '0, wb_dat_o, q;
  logic              wb_ack_o, trig_o, armed_o, irq_o;
  logic [1:0]        gate_o, line;
  int                mismatches = 0, checks = 0, trig_cnt = 0, base;
  ttd_row_s rows[16] = '{
    '{MODE_RISING_EDGE, 1'h0, 4'hC, 1'h0, 1'h1, 2'h0, 2'h1}, '{MODE_RISING_EDGE, 1'h0, 4'hC, 1'h1, 1'h0, 2'h0, 2'h0},
    '{MODE_FALLING_EDGE, 1'h0, 4'hC, 1'h1, 1'h0, 2'h0, 2'h1}, '{MODE_FALLING_EDGE, 1'h0, 4'hC, 1'h0, 1'h1, 2'h0, 2'h0},
    '{MODE_ANY_EDGE, 1'h0, 4'hC, 1'h0, 1'h1, 2'h0, 2'h1}, '{MODE_ANY_EDGE, 1'h0, 4'hC, 1'h1, 1'h0, 2'h0, 2'h1},
    '{MODE_HIGH_LEVEL, 1'h0, 4'hC, 1'h0, 1'h1, 2'h0, 2'h1}, '{MODE_HIGH_LEVEL, 1'h0, 4'hC, 1'h1, 1'h1, 2'h1, 2'h1},
    '{MODE_LOW_LEVEL, 1'h0, 4'hC, 1'h1, 1'h0, 2'h0, 2'h1}, '{MODE_LOW_LEVEL, 1'h0, 4'hC, 1'h0, 1'h0, 2'h1, 2'h1},
    '{MODE_DISABLED, 1'h0, 4'hC, 1'h0, 1'h1, 2'h0, 2'h0}, '{MODE_RISING_EDGE, 1'h1, 4'hC, 1'h0, 1'h1, 2'h0, 2'h1},
    '{MODE_RISING_EDGE, 1'h1, 4'h4, 1'h0, 1'h1, 2'h0, 2'h0}, '{MODE_RISING_EDGE, 1'h0, 4'h8, 1'h0, 1'h1, 2'h0, 2'h0},
    '{MODE_FALLING_EDGE, 1'h1, 4'hC, 1'h1, 1'h0, 2'h0, 2'h1}, '{MODE_LOW_LEVEL, 1'h1, 4'hC, 1'h0, 1'h0, 2'h1, 2'h1}};

  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (trig_o === 1'h1) trig_cnt <= trig_cnt + 1;

  ttd_trigger_detector ttd_trigger_detector_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .multipurpose_line_i(line), .rec_done_i(rec_done),
    .trig_o(trig_o), .gate_o(gate_o), .armed_o(armed_o), .irq_o(irq_o));
  ttd_ttl_source ttd_ttl_source_inst (.clk_i(core_clk_i), .line_o(line));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // single classic cycle: hold everything until ack is sampled high
  // no cycle count is assumed; only the watchdog ends a wait that never sees ack
  task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
    @(posedge core_clk_i);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= {idx, 2'h0}; dat <= d;
    do begin
      @(posedge core_clk_i);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
  endtask : bus

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc_wait

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  initial begin
    #2000000;
    mismatches++;
    test_done();
  end

  initial begin
    cyc_wait(16);
    rst_b_i <= 1'h1;
    bus(1'h0, IDX_LINE0_TRIG_MODE, 32'h0);
    chk(q, 32'h0, "mode reset");
    bus(1'h1, IDX_LINE0_TRIG_MODE, 32'h1F);
    bus(1'h1, IDX_LINE1_TRIG_MODE, 32'h8);
    bus(1'h0, IDX_LINE0_TRIG_MODE, 32'h0);
    chk(q, 32'h1F, "line0 mode");
    bus(1'h0, IDX_LINE1_TRIG_MODE, 32'h0);
    chk(q, 32'h8, "line1 mode");
    bus(1'h0, 16'h0001, 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("test registers done");
    foreach (rows[i]) begin
      rst_b_i <= 1'h0;
      cyc_wait(2);
      rst_b_i <= 1'h1;
      bus(1'h1, IDX_OR_TRIGGER_MASK, {28'h0, rows[i].msk});
      // mode is programmed before the line is driven as a trigger
      bus(1'h1, rows[i].ln ? IDX_LINE1_TRIG_MODE : IDX_LINE0_TRIG_MODE, {27'h0, rows[i].mode});
      ttd_ttl_source_inst.set_line(rows[i].ln, rows[i].l0);
      cyc_wait(6);
      base = trig_cnt;
      bus(1'h1, IDX_ACQ_CTRL, 32'h1);
      cyc_wait(5);
      chk(trig_cnt - base, rows[i].e0, "fire at arm");
      ttd_ttl_source_inst.set_line(rows[i].ln, rows[i].l1);
      cyc_wait(8);
      chk(trig_cnt - base, rows[i].e1, "fire after change");
      $display("test row %0d done", i);
    end
    // fresh reset: the last row may have left the block recording
    rst_b_i <= 1'h0;
    cyc_wait(2);
    rst_b_i <= 1'h1;
    bus(1'h1, IDX_IRQ_ENABLE, 32'h1);
    bus(1'h1, IDX_OR_TRIGGER_MASK, 32'hC);
    bus(1'h1, IDX_LINE0_TRIG_MODE, {27'h0, MODE_ANY_EDGE});
    bus(1'h1, IDX_ACQ_CTRL, 32'h1);
    cyc_wait(2);
    chk({31'h0, armed_o}, 32'h1, "armed before edges");
    base = trig_cnt;
    ttd_ttl_source_inst.set_line(0, 1'h0);
    ttd_ttl_source_inst.set_line(0, 1'h1);
    cyc_wait(8);
    chk(trig_cnt - base, 32'h1, "edges ignored while recording");
    chk({31'h0, armed_o}, 32'h0, "armed after fire");
    chk({31'h0, irq_o}, 32'h1, "irq raised");
    bus(1'h0, IDX_IRQ_STATUS, 32'h0);
    chk(q, 32'h1, "irq status");
    bus(1'h1, IDX_IRQ_CLEAR, 32'h1);
    cyc_wait(2);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    rec_done <= 1'h1;
    cyc_wait(1);
    rec_done <= 1'h0;
    bus(1'h0, IDX_IRQ_STATUS, 32'h0);
    chk(q, 32'h2, "done status");
    bus(1'h1, IDX_IRQ_ENABLE, 32'h0);
    bus(1'h1, IDX_ACQ_CTRL, 32'h1);
    // a low enable freezes the synchroniser too, so the edge waits for it
    ce <= 1'h0;
    ttd_ttl_source_inst.set_line(0, 1'h0);
    cyc_wait(6);
    chk(trig_cnt - base, 32'h1, "frozen while disabled");
    chk({31'h0, armed_o}, 32'h1, "armed held while frozen");
    ce <= 1'h1;
    cyc_wait(8);
    chk(trig_cnt - base, 32'h2, "rearmed fires again");
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    bus(1'h1, IDX_LINE1_TRIG_MODE, {27'h0, MODE_HIGH_LEVEL});
    ttd_ttl_source_inst.set_line(1, 1'h1);
    cyc_wait(6);
    chk({30'h0, gate_o}, 32'h2, "gate while high");
    bus(1'h0, IDX_ACQ_STATUS, 32'h0);
    chk(q, 32'h2A, "status gate levels state");
    ttd_ttl_source_inst.set_line(1, 1'h0);
    cyc_wait(6);
    chk({30'h0, gate_o}, 32'h0, "gate drops");
    $display("test recording cycle done");
    test_done();
  end
endmodule : tb
